// file: logic/btc_pkg.sv
/*
  Shared constants for the block transfer channel: processor command codes,
  byte-bus control codes, device status bits and the channel's own address.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package btc_pkg;

  // ------------------------------------------------------------
  // processor-side control codes (ctl byte)
  // ------------------------------------------------------------
  localparam logic [7:0] CTL_NONE    = 8'h00;
  localparam logic [7:0] CTL_ADDR    = 8'h01; // data lines carry address
  localparam logic [7:0] CTL_DATA_WR = 8'h02; // processor writes a byte
  localparam logic [7:0] CTL_DATA_RD = 8'h04; // processor reads a byte
  localparam logic [7:0] CTL_CMD     = 8'h08; // command byte
  localparam logic [7:0] CTL_STATUS  = 8'h10; // status request

  // ------------------------------------------------------------
  // channel command byte fields and codes
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_STOP    = 8'h00;
  localparam logic [7:0] CMD_DIR_IN  = 8'h01; // device to memory
  localparam logic [7:0] CMD_DIR_OUT = 8'h02; // memory to device
  localparam logic [7:0] CMD_GO      = 8'h04;
  localparam logic [7:0] CMD_SEL_FH  = 8'h10; // next data byte: final hi
  localparam logic [7:0] CMD_SEL_FL  = 8'h11;
  localparam logic [7:0] CMD_SEL_AH  = 8'h12;
  localparam logic [7:0] CMD_SEL_AL  = 8'h13;

  // ------------------------------------------------------------
  // device status bits and counts
  // ------------------------------------------------------------
  localparam int         STAT_BUSY_BIT = 4;
  localparam logic [7:0] STAT_FAIL_MSK = 8'hE0; // bits 7..5
  localparam int         MAX_DEVICES   = 25;
  localparam logic [7:0] CHAN_ADDR     = 8'hF0; // channel's own address

endpackage : btc_pkg

// file: logic/btc_bus_if.sv
/*
  Carrier joining the channel and a device controller over the byte bus.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface btc_bus_if;
  logic [7:0] data_out;   // channel to controllers
  logic [7:0] data_in;    // controllers to channel
  logic [7:0] ctl;        // control lines
  logic       hs_reply;   // handshake_reply
  logic       irq_line;   // interrupt_request_line
  logic       sys_clear;  // system_clear

  modport chan (output data_out, output ctl, output sys_clear,
                input data_in, input hs_reply, input irq_line);
  modport ctrl (input data_out, input ctl, input sys_clear,
                output data_in, output hs_reply, output irq_line);
endinterface : btc_bus_if
`default_nettype wire

// file: logic/btc_addr_unit.sv
/*
  Current address counter and final address register with compare.
  Assumes the channel supplies one-cycle load and increment strobes.
*/
`timescale 1ns/100ps
`default_nettype none
module btc_addr_unit
  import btc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // byte loads
  input  wire logic [7:0]  byte_i,
  input  wire logic [3:0]  load_i,   // fh, fl, ah, al
  input  wire logic        inc_i,
  // state
  output logic [15:0] cur_o,
  output logic [15:0] fin_o,
  output logic        match_o,
  output logic        carry_o
);
  logic [15:0] cur_reg;
  logic [15:0] fin_reg;
  logic [16:0] cur_sum;

  assign cur_sum = {1'b0, cur_reg} + 17'h00001;
  assign cur_o   = cur_reg;
  assign fin_o   = fin_reg;
  assign match_o = (cur_reg == fin_reg);
  // carry of the pending step, so the sequencer ends in the cycle the counter wraps to 0000
  assign carry_o = cur_sum[16];

  // ----------------------------------------------------------
  // registers: bytewise loads, increment
  // ----------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_reg   <= 16'h0000;
      fin_reg   <= 16'h0000;
    end else begin
      if (load_i[3]) fin_reg[15:8] <= byte_i;
      if (load_i[2]) fin_reg[7:0]  <= byte_i;
      if (load_i[1]) cur_reg[15:8] <= byte_i;
      if (load_i[0]) cur_reg[7:0]  <= byte_i;
      if (load_i == 4'h0 && inc_i)
        cur_reg <= cur_sum[15:0];
    end
  end
endmodule : btc_addr_unit
`default_nettype wire

// file: logic/btc_channel.sv
/*
  Block transfer channel end: processor byte port, memory port, and the
  channel side of the device byte bus.
  Assumes the memory answers a granted request within bounded time, and the
  processor ports are on the channel clock.
*/
`timescale 1ns/100ps
`default_nettype none
module btc_channel
  import btc_pkg::*;
(
  // clock and reset
  input  wire logic        CLK_I,
  input  wire logic        SYS_RST_I,
  // processor i/o bus
  input  wire logic [7:0]  PROC_DATA_I,
  input  wire logic [7:0]  PROC_CTL_I,
  output logic [7:0]       PROC_DATA_O,
  output logic             PROC_REPLY_O,
  output logic             PROC_IRQ_O,
  // high-speed memory bus
  output logic             MEM_REQ_O,
  input  wire logic        MEM_GNT_I,
  output logic             MEM_WE_O,
  output logic [15:0]      MEM_ADDR_O,
  output logic [15:0]      MEM_WDATA_O,
  input  wire logic [15:0] MEM_RDATA_I,
  input  wire logic        MEM_DONE_I,
  // device byte bus
  btc_bus_if.chan          bus
);
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0, ST_MREQ = 4'h1, ST_MWAIT = 4'h2, ST_STAT = 4'h3,
    ST_SWAIT = 4'h4, ST_XFER = 4'h5, ST_XWAIT = 4'h6, ST_INC  = 4'h7,
    ST_DONE  = 4'h8
  } btc_state_t;

  btc_state_t  state_reg, state_next;
  logic        addressed_reg, dir_out_reg, stop_reg, first_reg, irq_reg;
  logic [1:0]  sel_reg;       // pending address-byte destination
  logic        sel_vld_reg;
  logic        idx_reg;       // byte lane used from word buffer
  logic [15:0] memory_word_buffer_reg;
  logic [7:0]  pdata_reg, bdata_reg, bctl_reg;
  logic        preply_reg, mreq_reg, mwe_reg, clr_reg;
  logic        irq_out_reg;
  logic [2:0]  hs_sync, irq_sync;
  logic [15:0] cur, fin;
  logic        match, carry;
  logic [3:0]  ld;

  // synchronised pin inputs: stages 1 and 2 must both be high
  wire hs_ok    = hs_sync[1] & hs_sync[2];
  wire irq_pin  = irq_sync[1] & irq_sync[2];
  wire busy     = (state_reg != ST_IDLE) && (state_reg != ST_DONE);
  wire is_addr  = PROC_CTL_I == CTL_ADDR;
  // own address stays off the device bus: the controller keeps its selection
  wire own_addr = is_addr && (PROC_DATA_I == CHAN_ADDR);
  wire is_cmd   = addressed_reg && (PROC_CTL_I == CTL_CMD);
  wire is_wr    = addressed_reg && (PROC_CTL_I == CTL_DATA_WR);
  wire is_rd    = addressed_reg && (PROC_CTL_I == CTL_DATA_RD);
  wire is_stat  = addressed_reg && (PROC_CTL_I == CTL_STATUS);
  wire go_cmd   = is_cmd && !busy && PROC_DATA_I == CMD_GO;
  wire stop_cmd = is_cmd && busy && PROC_DATA_I == CMD_STOP;
  wire fail     = |(bus.data_in & STAT_FAIL_MSK);
  wire dev_busy = bus.data_in[STAT_BUSY_BIT];
  wire in_mem   = (state_reg == ST_MREQ) || (state_reg == ST_MWAIT);
  wire stop_now = (stop_reg || stop_cmd) && !in_mem;

  // address byte loads ignored while busy
  assign ld = (is_wr && sel_vld_reg && !busy) ?
              (4'h8 >> sel_reg) : 4'h0;

  btc_addr_unit u_addr (
    .clk_i   (CLK_I),
    .rst_i   (SYS_RST_I),
    .byte_i  (PROC_DATA_I),
    .load_i  (ld),
    .inc_i   (state_reg == ST_INC),
    .cur_o   (cur),
    .fin_o   (fin),
    .match_o (match),
    .carry_o (carry)
  );

  // ----------------------------------------------------------
  // transfer sequencer
  // ----------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:  if (go_cmd) state_next = dir_out_reg ? ST_MREQ : ST_STAT;
      ST_MREQ:  if (MEM_GNT_I) state_next = ST_MWAIT;
      ST_MWAIT: if (MEM_DONE_I) begin
                  if (stop_reg) state_next = ST_DONE;
                  else if (dir_out_reg) state_next = ST_STAT;
                  else if (match) state_next = ST_DONE;
                  else state_next = ST_INC;
                end
      // wait for the last reply to fall, so a stale one is never taken
      ST_STAT:  if (stop_now) state_next = ST_DONE;
                else if (!hs_ok) state_next = ST_SWAIT;
      ST_SWAIT: if (stop_now) state_next = ST_DONE;
                else if (hs_ok && !dev_busy)
                  state_next = fail ? ST_DONE : ST_XFER;
      ST_XFER:  if (stop_now) state_next = ST_DONE;
                else if (!hs_ok) state_next = ST_XWAIT;
      ST_XWAIT: if (stop_now) state_next = ST_DONE;
                else if (hs_ok) begin
                  if (!dir_out_reg && (match || idx_reg))
                    state_next = ST_MREQ;
                  else if (match) state_next = ST_DONE;
                  else state_next = ST_INC;
                end
      ST_INC:   if (carry || stop_now) state_next = ST_DONE;
                else if (dir_out_reg && cur[0] == 1'b1)
                  state_next = ST_MREQ;           // odd byte: word used
                else state_next = ST_STAT;
      ST_DONE:  state_next = ST_IDLE;
      default:  state_next = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------
  // state and control registers
  // ----------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      state_reg <= ST_IDLE;
      addressed_reg <= 1'b0;
      dir_out_reg <= 1'b0;
      stop_reg <= 1'b0;
      first_reg <= 1'b0;
      irq_reg <= 1'b0;
      sel_reg <= 2'h0;
      sel_vld_reg <= 1'b0;
      hs_sync <= 3'h0;
      irq_sync <= 3'h0;
    end else begin
      state_reg <= state_next;
      hs_sync <= {hs_sync[1:0], bus.hs_reply};
      irq_sync <= {irq_sync[1:0], bus.irq_line};
      if (is_addr) addressed_reg <= (PROC_DATA_I == CHAN_ADDR);
      if (is_cmd && !busy) begin
        if (PROC_DATA_I == CMD_DIR_OUT) dir_out_reg <= 1'b1;
        if (PROC_DATA_I == CMD_DIR_IN) dir_out_reg <= 1'b0;
        if (PROC_DATA_I[7:4] == CMD_SEL_FH[7:4]) begin
          sel_reg <= PROC_DATA_I[1:0];
          sel_vld_reg <= 1'b1;
        end
      end
      if (ld != 4'h0) sel_vld_reg <= 1'b0;
      // readout gives the high byte first, then the low byte
      if (state_next == ST_DONE) first_reg <= 1'b1;
      else if (is_rd && preply_reg) first_reg <= 1'b0;
      stop_reg <= busy && (stop_reg || stop_cmd);
      // raise wins over acknowledge in the same cycle
      if (state_next == ST_DONE) irq_reg <= 1'b1;
      else if (is_stat) irq_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // word buffer and byte steering
  // ----------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      memory_word_buffer_reg <= 16'h0000;
      idx_reg <= 1'b0;
    end else begin
      if (state_reg == ST_MWAIT && MEM_DONE_I && dir_out_reg)
        memory_word_buffer_reg <= MEM_RDATA_I;
      if (state_reg == ST_XWAIT && hs_ok && !dir_out_reg) begin
        if (cur[0]) memory_word_buffer_reg[7:0] <= bus.data_in;
        else memory_word_buffer_reg[15:8] <= bus.data_in;
      end
      idx_reg <= cur[0];
    end
  end

  // ----------------------------------------------------------
  // output drivers, all registered
  // ----------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      pdata_reg <= 8'h00;
      preply_reg <= 1'b0;
      bdata_reg <= 8'h00;
      bctl_reg <= 8'h00;
      mreq_reg <= 1'b0;
      mwe_reg <= 1'b0;
      clr_reg <= 1'b1;
      irq_out_reg <= 1'b0;
    end else begin
      clr_reg <= 1'b0;
      irq_out_reg <= irq_reg | irq_pin;
      mreq_reg <= in_mem && state_next != ST_DONE && state_next != ST_IDLE
                  && !(state_reg == ST_MWAIT && MEM_DONE_I);
      mwe_reg <= !dir_out_reg;
      preply_reg <= (addressed_reg && PROC_CTL_I != CTL_NONE) ||
                    (!addressed_reg && hs_ok);
      if (is_stat)   // device status with busy bit forced low
        pdata_reg <= bus.data_in & ~(8'h01 << STAT_BUSY_BIT);
      else if (is_rd)
        pdata_reg <= first_reg ? cur[15:8] : cur[7:0];
      else pdata_reg <= bus.data_in;
      if (!addressed_reg && !busy && !own_addr) begin
        bdata_reg <= PROC_DATA_I;
        bctl_reg <= PROC_CTL_I;
      end else if (state_reg == ST_SWAIT) begin
        bctl_reg <= CTL_STATUS;
      end else if (state_reg == ST_XWAIT) begin
        bctl_reg <= dir_out_reg ? CTL_DATA_WR : CTL_DATA_RD;
        bdata_reg <= cur[0] ? memory_word_buffer_reg[7:0]
                            : memory_word_buffer_reg[15:8];
      end else bctl_reg <= CTL_NONE;
    end
  end

  assign PROC_DATA_O  = pdata_reg;
  assign PROC_REPLY_O = preply_reg;
  assign PROC_IRQ_O   = irq_out_reg;
  assign MEM_REQ_O    = mreq_reg;
  assign MEM_WE_O     = mwe_reg;
  assign MEM_ADDR_O   = {cur[15:1], 1'b0};
  assign MEM_WDATA_O  = memory_word_buffer_reg;
  assign bus.data_out  = bdata_reg;
  assign bus.ctl       = bctl_reg;
  assign bus.sys_clear = clr_reg;
endmodule : btc_channel
`default_nettype wire

// file: logic/btc_device_ctrl.sv
/*
  Device controller end of the byte bus: address decode, byte handshake and
  attention from an interrupt queue flip-flop.
  Assumes the user side presents bytes and status on the channel clock.
*/
`timescale 1ns/100ps
`default_nettype none
module btc_device_ctrl
  import btc_pkg::*;
#(
  parameter logic [7:0] DEV_ADDR = 8'h01
) (
  // clock and reset
  input  wire logic       CLK_I,
  input  wire logic       SYS_RST_I,
  // user side
  input  wire logic [7:0] USR_RDATA_I,
  input  wire logic [7:0] USR_STATUS_I,
  input  wire logic       USR_EVENT_I,
  output logic [7:0]      USR_WDATA_O,
  output logic            USR_WSTB_O,
  // device byte bus
  btc_bus_if.ctrl         bus
);
  logic       sel_reg, reply_reg, queue_reg, wstb_reg;
  logic [7:0] din_reg, wdata_reg;
  wire addr_hit = bus.ctl == CTL_ADDR && bus.data_out == DEV_ADDR;

  // ----------------------------------------------------------
  // selection, handshake, queue flip-flop
  // ----------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I || bus.sys_clear) begin
      sel_reg <= 1'b0;
      reply_reg <= 1'b0;
      queue_reg <= 1'b0;
      wstb_reg <= 1'b0;
      din_reg <= 8'h00;
      wdata_reg <= 8'h00;
    end else begin
      wstb_reg <= 1'b0;
      reply_reg <= 1'b0;
      if (bus.ctl == CTL_ADDR) sel_reg <= addr_hit;
      if (addr_hit) reply_reg <= 1'b1;
      else if (sel_reg) begin
        unique case (bus.ctl)
          CTL_DATA_WR: begin
            wdata_reg <= bus.data_out;
            wstb_reg <= !reply_reg;
            reply_reg <= 1'b1;
          end
          CTL_DATA_RD: begin
            din_reg <= USR_RDATA_I;
            reply_reg <= 1'b1;
          end
          CTL_STATUS: begin
            din_reg <= USR_STATUS_I;
            reply_reg <= 1'b1;
            queue_reg <= 1'b0;
          end
          default: reply_reg <= 1'b0;
        endcase
      end
      if (USR_EVENT_I) queue_reg <= 1'b1;
    end
  end

  assign bus.data_in  = din_reg;
  assign bus.hs_reply = reply_reg;
  assign bus.irq_line = queue_reg;
  assign USR_WDATA_O  = wdata_reg;
  assign USR_WSTB_O   = wstb_reg;
endmodule : btc_device_ctrl
`default_nettype wire

// file: sim/btc_bus_asserts.sv
/*
  Concurrent checks on the byte bus between the channel and one controller.
  Assumes one clock, a synchronous active-high reset and a single controller.
*/
`timescale 1ns/100ps
`default_nettype none
module btc_bus_asserts
  import btc_pkg::*;
#(
  parameter logic [7:0] DEV_ADDR = 8'h01
) (
  // clock and reset
  input  wire logic       CLK_I,
  input  wire logic       SYS_RST_I,
  // byte bus
  input  wire logic [7:0] data_out,
  input  wire logic [7:0] data_in,
  input  wire logic [7:0] ctl,
  input  wire logic       hs_reply,
  input  wire logic       irq_line,
  input  wire logic       sys_clear
);
  // ------------------------------------------------------------
  // selection tracker
  // ------------------------------------------------------------
  logic hit;
  logic sel_reg;
  logic sel_next;

  // any other address or a clear drops the selection
  assign hit      = (ctl == CTL_ADDR) && (data_out == DEV_ADDR);
  assign sel_next = hit ? 1'b1 :
                    ((ctl == CTL_ADDR) || sys_clear) ? 1'b0 : sel_reg;

  // tracker follows the bus, not the controller's own state
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) sel_reg <= 1'b0;
    else           sel_reg <= sel_next;
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  chk_addr_reply: assert property (hit |=> hs_reply)
    else $error("no reply to own address");
  chk_unsel_quiet: assert property (!sel_reg && !hit |=> !hs_reply)
    else $error("reply while not selected");
  chk_wr_reply: assert property (
    sel_reg && ctl == CTL_DATA_WR |=> hs_reply)
    else $error("no reply to output byte");
  chk_rd_reply: assert property (
    sel_reg && (ctl == CTL_DATA_RD || ctl == CTL_STATUS) |=> hs_reply)
    else $error("no reply to input byte");
  chk_clear_pulse: assert property (
    disable iff (1'b0) $fell(SYS_RST_I) |-> ##[0:1] sys_clear)
    else $error("no clear after reset");
  chk_clear_once: assert property (sys_clear |=> !sys_clear)
    else $error("clear longer than a cycle");
  chk_irq_quiet: assert property (
    disable iff (1'b0) $fell(SYS_RST_I) |-> !irq_line ##1 !irq_line)
    else $error("attention after reset");
  chk_clear_desel: assert property (
    sys_clear && ctl != CTL_ADDR |=> ##1 !hs_reply)
    else $error("reply after clear");
endmodule : btc_bus_asserts
`default_nettype wire

// file: sim/block_transfer_channel_bench.sv
/*
  Self-checking bench: channel and one controller joined by the carrier,
  with a small memory model. Assumes package and design compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module block_transfer_channel_bench
  import btc_pkg::*;
;
  localparam logic [7:0] DEV = 8'h05;
  // dir, start, final, bytes expected on the device side
  localparam logic [47:0] ROWS [6] = '{
    {CMD_DIR_OUT, 16'h0000, 16'h0000, 8'h01},
    {CMD_DIR_OUT, 16'h0000, 16'h0003, 8'h04},
    {CMD_DIR_OUT, 16'h0004, 16'h0006, 8'h03},
    {CMD_DIR_OUT, 16'hFFFE, 16'h0001, 8'h02},
    {CMD_DIR_IN,  16'h0008, 16'h0009, 8'h02},
    {CMD_DIR_IN,  16'h000A, 16'h000A, 8'h01}};
  logic        clk, rst, p_reply, p_irq, m_req, m_gnt, m_we, m_done;
  logic [7:0]  p_data, p_ctl, p_out, p_q, u_rd, u_st, u_wd;
  logic        u_ev, u_stb;
  logic [15:0] m_addr, m_wd, m_rd;
  logic [15:0] mem [16];
  logic [1:0]  mcnt;
  logic [7:0]  wq [$];
  int          n_mismatch, checks_done;

  btc_bus_if btc_bus_if_i ();
  btc_channel btc_channel_i (.CLK_I(clk), .SYS_RST_I(rst),
    .PROC_DATA_I(p_data), .PROC_CTL_I(p_ctl), .PROC_DATA_O(p_out),
    .PROC_REPLY_O(p_reply), .PROC_IRQ_O(p_irq), .MEM_REQ_O(m_req),
    .MEM_GNT_I(m_gnt), .MEM_WE_O(m_we), .MEM_ADDR_O(m_addr),
    .MEM_WDATA_O(m_wd), .MEM_RDATA_I(m_rd), .MEM_DONE_I(m_done),
    .bus(btc_bus_if_i.chan));
  btc_device_ctrl #(.DEV_ADDR(DEV)) btc_device_ctrl_i (.CLK_I(clk),
    .SYS_RST_I(rst), .USR_RDATA_I(u_rd), .USR_STATUS_I(u_st),
    .USR_EVENT_I(u_ev), .USR_WDATA_O(u_wd), .USR_WSTB_O(u_stb),
    .bus(btc_bus_if_i.ctrl));
  btc_bus_asserts #(.DEV_ADDR(DEV)) btc_bus_asserts_i (.CLK_I(clk),
    .SYS_RST_I(rst), .data_out(btc_bus_if_i.data_out),
    .data_in(btc_bus_if_i.data_in), .ctl(btc_bus_if_i.ctl),
    .hs_reply(btc_bus_if_i.hs_reply), .irq_line(btc_bus_if_i.irq_line),
    .sys_clear(btc_bus_if_i.sys_clear));

  // ------------------------------------------------------------
  // clock, memory model, byte collector
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // memory answers four cycles after request; write lands with done
  always @(negedge clk) begin
    if (mcnt == 2'd3 && m_we) mem[m_addr[4:1]] = m_wd;
    m_gnt  <= m_req;
    m_rd   <= mem[m_addr[4:1]];
    m_done <= (mcnt == 2'd3);
    mcnt   <= (m_req && mcnt != 2'd3) ? mcnt + 2'd1 : 2'd0;
  end

  always @(posedge clk) begin
    if (u_stb === 1'b1) wq.push_back(u_wd);
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic chk_flag(input string nm, input logic e, g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %b got %b", nm, e, g);
    end
  endtask : chk_flag

  // one processor transfer, held until the reply is sampled
  task automatic pio(input logic [7:0] c, d);
    int n;
    @(negedge clk);
    p_ctl  = c;
    p_data = d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (p_reply !== 1'b1 && n < 40);
    p_q = p_out;
    @(negedge clk);
    p_ctl = CTL_NONE;
    if (n >= 40) chk_flag("proc reply", 1'b1, 1'b0);
  endtask : pio

  task automatic wirq(input int lim);
    int n;
    n = 0;
    while (p_irq !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk_flag("irq", 1'b1, p_irq);
  endtask : wirq

  // four address bytes, direction, then go
  task automatic run(input logic [7:0] dir, input logic [15:0] sa, fa);
    logic [31:0] v;
    v = {fa, sa};
    wq.delete();
    pio(CTL_ADDR, CHAN_ADDR);
    for (int i = 0; i < 4; i++) begin
      pio(CTL_CMD, CMD_SEL_FH + 8'(i));
      pio(CTL_DATA_WR, v[31-8*i -: 8]);
    end
    pio(CTL_CMD, dir);
    pio(CTL_CMD, CMD_GO);
  endtask : run

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    logic [7:0]  dir, nb, hi;
    logic [15:0] sa, fa, a;
    int          n;
    {rst, p_data, p_ctl, u_rd, u_st, u_ev} = {1'b1, 8'h00, CTL_NONE,
                                             8'hA5, 8'h00, 1'b0};
    for (int i = 0; i < 16; i++) mem[i] = {8'hC0 | 8'(i), 8'h40 | 8'(i)};
    repeat (3) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    repeat (4) @(negedge clk);
    pio(CTL_ADDR, DEV);
    // table of ordinary transfers
    foreach (ROWS[r]) begin
      {dir, sa, fa, nb} = ROWS[r];
      run(dir, sa, fa);
      wirq(3000);
      if (dir == CMD_DIR_OUT) begin
        chk("bytes out", 16'(nb), 16'(wq.size()));
        foreach (wq[k]) begin
          a = sa + 16'(k);
          chk("byte", a[0] ? mem[a[4:1]][7:0] : mem[a[4:1]][15:8],
              wq[k]);
        end
      end else begin
        chk("word in", 16'hA5A5, mem[sa[4:1]]);
      end
      if (16'(nb) == fa - sa + 16'd1) begin
        pio(CTL_DATA_RD, 8'h00);
        hi = p_q;
        pio(CTL_DATA_RD, 8'h00);
        chk("addr readout", fa, {hi, p_q});
      end
      pio(CTL_STATUS, 8'h00);
      repeat (2) @(posedge clk);
      chk_flag("irq clear", 1'b0, p_irq);
      $display("row %0d done", r);
    end
    // readdressing the device returns to pass-through
    pio(CTL_ADDR, DEV);
    wq.delete();
    pio(CTL_DATA_WR, 8'h5A);
    chk("pass write", 16'h005A, 16'(wq.size() ? wq[0] : 8'h00));
    pio(CTL_DATA_RD, 8'h00);
    chk("pass read", 16'h00A5, 16'(p_q));
    $display("pass-through done");
    // device fault ends the block before any byte
    u_st = 8'h20;
    run(CMD_DIR_OUT, 16'h0000, 16'h0003);
    wirq(3000);
    chk("fault bytes", 16'h0000, 16'(wq.size()));
    @(negedge clk) u_st = 8'h30;
    pio(CTL_STATUS, 8'h00);
    chk("status", 16'h0020, 16'(p_q));
    u_st = 8'h00;
    $display("fault done");
    // stop in mid-block; nothing moves afterwards
    run(CMD_DIR_OUT, 16'h0000, 16'h00FE);
    repeat (150) @(negedge clk);
    pio(CTL_CMD, CMD_STOP);
    wirq(500);
    n = wq.size();
    repeat (100) @(posedge clk);
    chk("after stop", 16'(n), 16'(wq.size()));
    chk_flag("stopped early", 1'b1, n < 255);
    pio(CTL_STATUS, 8'h00);
    $display("stop done");
    // attention from the controller's queue
    @(negedge clk) u_ev = 1'b1;
    @(negedge clk) u_ev = 1'b0;
    wirq(12);
    $display("attention done");
    // reset in mid-block
    run(CMD_DIR_OUT, 16'h0000, 16'h00FE);
    repeat (50) @(negedge clk);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    chk_flag("irq after reset", 1'b0, p_irq);
    n = wq.size();
    repeat (100) @(posedge clk);
    chk("after reset", 16'(n), 16'(wq.size()));
    chk_flag("req after reset", 1'b0, m_req);
    $display("reset done");
    finish_test();
  end
endmodule : block_transfer_channel_bench
`default_nettype wire
